/* cpu_state_consts.vh */
`ifndef CPU_STATE_CONSTS_VH
`define CPU_STATE_CONSTS_VH
// ========================================
// Register byte offsets (word aligned)
`define OFS_STATUS1 12'h000
`define OFS_STATUS2 12'h004
`define OFS_PC 12'h008
`define OFS_RTC 12'h00c
`define OFS_TCTRL 12'h010
`define OFS_MON 12'h014
`define OFS_BP 12'h018
`define OFS_STATE 12'h01c
`define OFS_CMD 12'h020
`define OFS_NEWST1 12'h024
`define OFS_NEWST2 12'h028
`define OFS_ENTRY 12'h02c
`define OFS_SAVPC 12'h030
`define OFS_SAVST1 12'h034
`define OFS_SAVST2 12'h038
`define OFS_SAVRTC 12'h03c
`define OFS_GREG 12'h100
`define OFS_PAGE 12'h200
// ========================================
// Field positions
`define ST1_SETSEL 14
`define TC_RTCEN 0
`define TC_RTCINT 1
`define TC_MONEN 2
`define CMD_RESUME 0
// ========================================
// Reset values
`define RST_WORD16 16'h0000
`define RST_ENTRY 16'h0080
// ========================================
// Timing
`define CLK_PERIOD_NS 40
`define INT_TICK_NS 1000000
`define EXT_TICK_MIN_NS 20000
// ========================================
// Entry sequence states
`define ST_IDLE 3'h0
`define ST_SAVE 3'h1
`define ST_LOADST 3'h2
`define ST_LOADP 3'h3
`define ST_ENABLE 3'h4
// Interrupt classes
`define CLS_NONE 2'h0
`define CLS_ONE 2'h1
`define CLS_TWO 2'h2
`define CLS_THREE 2'h3
`endif

/* cpu_state_timers.v */
`timescale 1ns/1ps
`include "cpu_state_consts.vh"
// Notes on behaviour
// - One set of sixteen 16-bit registers, optionally a second set.
// - Only one set active; status1 bit 14 picks it.
// - Program counter advances by one or two by instruction length.
// - Jumps load the counter; next fetch uses it after the instruction.
// - Sixty-four writable page bases; every reference is base plus relative.
// - With read stop on, halt after a data read at breakpoint address.
// - With write stop on, halt after a data write at breakpoint address.
// - On a breakpoint match, finish the current instruction, then stop.
// - Compare all references; for two-word accesses only the even one.
// - Breakpoint address loads only from the panel, never by program.
// - A 32-bit real-time counter counts each tick of the chosen source.
// - Low half rolling from all ones to zero raises overflow interrupt.
// - Timer control sets load and enables; counts only in run mode.
// - A 16-bit monitor counter, loaded and enabled, decrements per tick.
// - At zero it raises its interrupt and clears its own enable.
// - Monitor decrements only while instructions run in run mode.
// - A panel switch picks internal or external ticks for both counters.
// - Panel real-time disable stops the counter over the program enable.
// - Internal tick runs at 1000 Hz.
// - External ticks up to 50 kHz are all counted.
// - Three interrupt classes, first highest; highest pending served first.
// - Entry: stop, lock out, save state, reload status, jump, re-enable.
module cpu_state_timers #(
    parameter TWO_SETS = 1,
    parameter INT_TICK_CYC = `INT_TICK_NS / `CLK_PERIOD_NS
) (
    // Clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // Maintenance panel
    input wire panelBpLoad,
    input wire [15:0] panelBpAddr,
    input wire readStopEn,
    input wire writeStopEn,
    input wire extClkSel,
    input wire rtcDisable,
    input wire extTick,
    // Processor sequencing
    input wire runMode,
    input wire instrDone,
    input wire instrDouble,
    input wire jumpTaken,
    input wire [15:0] jumpTarget,
    // Memory reference stream
    input wire memRefValid,
    input wire memRefWrite,
    input wire memRefOdd,
    input wire [5:0] memRefPage,
    input wire [15:0] memRefAddr,
    // General register access
    input wire [3:0] regSel,
    input wire regWe,
    input wire [15:0] regWData,
    // Interrupt requests from other units
    input wire class1Req,
    input wire class2Req,
    input wire class3Req,
    // Outputs
    output reg [15:0] pc,
    output reg [15:0] physAddr,
    output reg [15:0] regOut,
    output reg stopped,
    output reg intLockout,
    output reg abortSeq,
    output reg [1:0] entryClass
);

    // ========================================
    // Storage
    reg [15:0] gregs [0:31];
    reg [15:0] pages [0:63];
    reg [15:0] status1, status2, newSt1, newSt2, entryBase;
    reg [15:0] bpAddr, mon, savPc, savSt1, savSt2;
    reg [31:0] rtc, savRtc;
    reg rtcEn, rtcIntEn, monEn, bpHit;
    reg c1Pend, c3Pend, c2ExtPend, rtcPend, monPend;
    reg [2:0] state;
    reg [1:0] curCls;
    reg [15:0] intDiv;
    reg extPrev;
    // Bus data-phase holders
    reg dWrite;
    reg [11:0] dAddr;
    integer i;

    // Absolute register index for the active set
    function [4:0] gIndex;
        input [15:0] st1;
        input [3:0] sel;
        begin
            gIndex = {(TWO_SETS != 0) & st1[`ST1_SETSEL], sel};
        end
    endfunction

    // Offset match for a word register
    function isOfs;
        input [11:0] a;
        input [11:0] ofs;
        begin
            isOfs = (a[11:2] == ofs[11:2]);
        end
    endfunction

    // ========================================
    // Tick source
    wire intTickNow = (intDiv == INT_TICK_CYC[15:0] - 16'h0001);
    wire extTickNow = extTick & ~extPrev;
    wire tick = extClkSel ? extTickNow : intTickNow;
    wire running = runMode & ~stopped & (state == `ST_IDLE);
    wire rtcStep = tick & running & rtcEn & ~rtcDisable;
    wire monStep = tick & running & monEn & (mon != `RST_WORD16);
    wire [16:0] rtcLowNext = {1'b0, rtc[15:0]} + 17'h00001;
    wire rtcOvf = rtcStep & rtcLowNext[16];
    wire monZero = monEn & (mon == `RST_WORD16);

    // Bus address and data phase qualifiers
    wire aValid = hsel & htrans[1] & hready;
    wire busWr = ce & dWrite;
    wire wrTctrl = busWr & isOfs(dAddr, `OFS_TCTRL);
    wire wrCmd = busWr & isOfs(dAddr, `OFS_CMD);
    wire wrGreg = busWr & (dAddr[11:6] == `OFS_GREG >> 6);
    wire wrPage = busWr & (dAddr[11:8] == `OFS_PAGE >> 8);

    // Breakpoint compare on even references only
    wire bpMatch = memRefValid & ~memRefOdd & (memRefAddr == bpAddr) &
        ((~memRefWrite & readStopEn) | (memRefWrite & writeStopEn));

    // Interrupt priority
    wire c2Any = c2ExtPend | rtcPend | monPend;
    wire [1:0] winCls = c1Pend ? `CLS_ONE : (c2Any ? `CLS_TWO :
        (c3Pend ? `CLS_THREE : `CLS_NONE));

    // ========================================
    // Bus slave: zero wait state, always OKAY
    always @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            dWrite <= 1'b0;
            dAddr <= 12'h000;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            dWrite <= aValid & hwrite;
            dAddr <= haddr;
            hrdata <= 32'h00000000;
            if (aValid & ~hwrite) begin
                if (haddr[11:6] == `OFS_GREG >> 6)
                    hrdata <= {16'h0000, gregs[gIndex(status1, haddr[5:2])]};
                else if (haddr[11:8] == `OFS_PAGE >> 8)
                    hrdata <= {16'h0000, pages[haddr[7:2]]};
                else begin
                    case (haddr[11:2])
                        `OFS_STATUS1 >> 2: hrdata <= {16'h0000, status1};
                        `OFS_STATUS2 >> 2: hrdata <= {16'h0000, status2};
                        `OFS_PC >> 2: hrdata <= {16'h0000, pc};
                        `OFS_RTC >> 2: hrdata <= rtc;
                        `OFS_TCTRL >> 2: hrdata <= {29'h00000000, monEn, rtcIntEn, rtcEn};
                        `OFS_MON >> 2: hrdata <= {16'h0000, mon};
                        `OFS_BP >> 2: hrdata <= {16'h0000, bpAddr};
                        `OFS_STATE >> 2: hrdata <= {22'h000000, state, curCls,
                            c1Pend, c2Any, c3Pend, bpHit, stopped};
                        `OFS_NEWST1 >> 2: hrdata <= {16'h0000, newSt1};
                        `OFS_NEWST2 >> 2: hrdata <= {16'h0000, newSt2};
                        `OFS_ENTRY >> 2: hrdata <= {16'h0000, entryBase};
                        `OFS_SAVPC >> 2: hrdata <= {16'h0000, savPc};
                        `OFS_SAVST1 >> 2: hrdata <= {16'h0000, savSt1};
                        `OFS_SAVST2 >> 2: hrdata <= {16'h0000, savSt2};
                        `OFS_SAVRTC >> 2: hrdata <= savRtc;
                        default: hrdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // ========================================
    // General registers and page bases
    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < 32; i = i + 1)
                gregs[i] <= `RST_WORD16;
            for (i = 0; i < 64; i = i + 1)
                pages[i] <= `RST_WORD16;
        end else if (ce) begin
            if (wrGreg)
                gregs[gIndex(status1, dAddr[5:2])] <= hwdata[15:0];
            if (regWe)
                gregs[gIndex(status1, regSel)] <= regWData;
            if (wrPage)
                pages[dAddr[7:2]] <= hwdata[15:0];
        end
    end

    // Register read port and relocated address
    always @(posedge clk) begin
        if (rst) begin
            regOut <= `RST_WORD16;
            physAddr <= `RST_WORD16;
        end else if (ce) begin
            regOut <= gregs[gIndex(status1, regSel)];
            physAddr <= pages[memRefPage] + memRefAddr;
        end
    end

    // ========================================
    // Tick generation
    always @(posedge clk) begin
        if (rst) begin
            intDiv <= 16'h0000;
            extPrev <= 1'b0;
        end else if (ce) begin
            extPrev <= extTick;
            intDiv <= intTickNow ? 16'h0000 : intDiv + 16'h0001;
        end
    end

    // Real-time and monitor counters
    always @(posedge clk) begin
        if (rst) begin
            rtc <= 32'h00000000;
            mon <= `RST_WORD16;
            rtcEn <= 1'b0;
            rtcIntEn <= 1'b0;
            monEn <= 1'b0;
        end else if (ce) begin
            if (busWr & isOfs(dAddr, `OFS_RTC))
                rtc <= hwdata;
            else if (rtcStep)
                rtc <= {rtc[31:16] + {15'h0000, rtcLowNext[16]}, rtcLowNext[15:0]};
            if (busWr & isOfs(dAddr, `OFS_MON))
                mon <= hwdata[15:0];
            else if (monStep)
                mon <= mon - 16'h0001;
            if (wrTctrl) begin
                rtcEn <= hwdata[`TC_RTCEN];
                rtcIntEn <= hwdata[`TC_RTCINT];
            end
            if (monZero)
                monEn <= 1'b0;
            else if (wrTctrl)
                monEn <= hwdata[`TC_MONEN];
        end
    end

    // ========================================
    // Breakpoint register and stop
    always @(posedge clk) begin
        if (rst) begin
            bpAddr <= `RST_WORD16;
            bpHit <= 1'b0;
            stopped <= 1'b0;
        end else if (ce) begin
            if (panelBpLoad)
                bpAddr <= panelBpAddr;
            if (instrDone) begin
                if (bpHit | bpMatch)
                    stopped <= 1'b1;
                bpHit <= 1'b0;
            end else if (bpMatch)
                bpHit <= 1'b1;
            if (wrCmd & hwdata[`CMD_RESUME] & ~(instrDone & (bpHit | bpMatch)))
                stopped <= 1'b0;
        end
    end

    // ========================================
    // Interrupt pending, one level of queuing each
    always @(posedge clk) begin
        if (rst) begin
            c1Pend <= 1'b0;
            c2ExtPend <= 1'b0;
            rtcPend <= 1'b0;
            monPend <= 1'b0;
            c3Pend <= 1'b0;
        end else if (ce) begin
            if (state == `ST_SAVE) begin
                case (curCls)
                    `CLS_ONE: c1Pend <= 1'b0;
                    `CLS_TWO: begin
                        if (c2ExtPend)
                            c2ExtPend <= 1'b0;
                        else if (rtcPend)
                            rtcPend <= 1'b0;
                        else
                            monPend <= 1'b0;
                    end
                    `CLS_THREE: c3Pend <= 1'b0;
                    default: c1Pend <= c1Pend;
                endcase
            end
            // New events win over the clear above
            if (class1Req)
                c1Pend <= 1'b1;
            if (class2Req)
                c2ExtPend <= 1'b1;
            if (rtcOvf & rtcIntEn)
                rtcPend <= 1'b1;
            if (monZero)
                monPend <= 1'b1;
            if (class3Req)
                c3Pend <= 1'b1;
        end
    end

    // ========================================
    // Program counter and interrupt entry sequence
    always @(posedge clk) begin
        if (rst) begin
            state <= `ST_IDLE;
            curCls <= `CLS_NONE;
            pc <= `RST_WORD16;
            status1 <= `RST_WORD16;
            status2 <= `RST_WORD16;
            newSt1 <= `RST_WORD16;
            newSt2 <= `RST_WORD16;
            entryBase <= `RST_ENTRY;
            savPc <= `RST_WORD16;
            savSt1 <= `RST_WORD16;
            savSt2 <= `RST_WORD16;
            savRtc <= 32'h00000000;
            intLockout <= 1'b0;
            abortSeq <= 1'b0;
            entryClass <= `CLS_NONE;
        end else if (ce) begin
            abortSeq <= 1'b0;
            if (busWr & isOfs(dAddr, `OFS_NEWST1))
                newSt1 <= hwdata[15:0];
            if (busWr & isOfs(dAddr, `OFS_NEWST2))
                newSt2 <= hwdata[15:0];
            if (busWr & isOfs(dAddr, `OFS_ENTRY))
                entryBase <= hwdata[15:0];
            case (state)
                `ST_IDLE: begin
                    if (busWr & isOfs(dAddr, `OFS_STATUS1))
                        status1 <= hwdata[15:0];
                    if (busWr & isOfs(dAddr, `OFS_STATUS2))
                        status2 <= hwdata[15:0];
                    if (busWr & isOfs(dAddr, `OFS_PC))
                        pc <= hwdata[15:0];
                    else if (instrDone & running)
                        pc <= jumpTaken ? jumpTarget :
                            pc + (instrDouble ? 16'h0002 : 16'h0001);
                    if (winCls != `CLS_NONE && running) begin
                        state <= `ST_SAVE;
                        curCls <= winCls;
                        intLockout <= 1'b1;
                        abortSeq <= 1'b1;
                    end
                end
                `ST_SAVE: begin
                    savPc <= pc;
                    savSt1 <= status1;
                    savSt2 <= status2;
                    savRtc <= rtc;
                    state <= `ST_LOADST;
                end
                `ST_LOADST: begin
                    status1 <= newSt1;
                    status2 <= newSt2;
                    state <= `ST_LOADP;
                end
                `ST_LOADP: begin
                    pc <= entryBase + {12'h000, curCls, 2'b00};
                    entryClass <= curCls;
                    state <= `ST_ENABLE;
                end
                `ST_ENABLE: begin
                    intLockout <= 1'b0;
                    curCls <= `CLS_NONE;
                    state <= `ST_IDLE;
                end
                default: state <= `ST_IDLE;
            endcase
        end
    end

endmodule // cpu_state_timers

/* cpu_state_checker.sv */
`timescale 1ns/1ps
`include "cpu_state_consts.vh"
// ========================================
// Checker on the sequencing and entry ports
module cpu_state_checker (
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire ce,
    // Sequencing inputs
    input wire runMode,
    input wire instrDone,
    input wire instrDouble,
    input wire jumpTaken,
    input wire [15:0] jumpTarget,
    input wire class1Req,
    input wire readStopEn,
    input wire writeStopEn,
    // Watched outputs
    input wire [15:0] pc,
    input wire stopped,
    input wire intLockout,
    input wire abortSeq,
    input wire [1:0] entryClass
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Instruction boundary with the processor free to move on
    sequence step_s;
        ce && runMode && instrDone && !stopped && !intLockout && !abortSeq;
    endsequence
    // Lockout spans the whole entry sequence, then drops
    sequence lock_s;
        intLockout [*4] ##1 !intLockout;
    endsequence
    sequence served1_s;
        $fell(intLockout) && entryClass == `CLS_ONE;
    endsequence
    pc_single_step_a: assert property (step_s ##0 (!jumpTaken && !instrDouble) |=> pc == $past(pc) + 16'h0001)
        else $error("pc did not advance by one");
    pc_double_step_a: assert property (step_s ##0 (!jumpTaken && instrDouble) |=> pc == $past(pc) + 16'h0002)
        else $error("pc did not advance by two");
    pc_jump_load_a: assert property (step_s ##0 jumpTaken |=> abortSeq || pc == $past(jumpTarget))
        else $error("pc did not take the jump target");
    lockout_span_a: assert property ($rose(intLockout) |-> lock_s)
        else $error("lockout length wrong");
    abort_pulse_a: assert property (abortSeq |-> intLockout ##1 !abortSeq)
        else $error("abort pulse wrong");
    entry_class_a: assert property ($fell(intLockout) |-> entryClass != `CLS_NONE)
        else $error("entry class not recorded");
    class_one_first_a: assert property (ce && class1Req && runMode && !stopped && !intLockout |->
        ##[1:12] served1_s) else $error("first class request not served");
    stop_at_end_a: assert property ($rose(stopped) |-> $past(instrDone))
        else $error("stop before instruction end");
    stop_switch_a: assert property ($rose(stopped) |-> $past(readStopEn || writeStopEn))
        else $error("stop without panel switch");
endmodule // cpu_state_checker
bind cpu_state_timers cpu_state_checker cpu_state_checker_inst (.clk(clk), .rst(rst), .ce(ce), .runMode(runMode),
    .instrDone(instrDone), .instrDouble(instrDouble), .jumpTaken(jumpTaken), .jumpTarget(jumpTarget),
    .class1Req(class1Req), .readStopEn(readStopEn), .writeStopEn(writeStopEn), .pc(pc), .stopped(stopped),
    .intLockout(intLockout), .abortSeq(abortSeq), .entryClass(entryClass));

/* panel_clock_model.sv */
`timescale 1ns/1ps
// ========================================
// Maintenance panel and external timing clock
module panel_clock_model #(
    parameter HALF = 250
) (
    // Clock
    input wire clk,
    // Bench commands
    input wire tickRun,
    input wire bpReq,
    input wire [15:0] bpValue,
    // Panel outputs
    output logic extTick,
    output logic panelBpLoad,
    output logic [15:0] panelBpAddr
);
    int cnt = 0;
    initial extTick = 1'b0;
    initial panelBpLoad = 1'b0;
    initial panelBpAddr = 16'h0000;
    // External clock stands still low between bursts
    always @(posedge clk) begin
        if (!tickRun) begin
            extTick <= 1'b0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            extTick <= ~extTick;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // Manual breakpoint load; address lines scramble while idle
    always @(posedge clk) begin
        panelBpLoad <= bpReq;
        panelBpAddr <= bpReq ? bpValue : ~panelBpAddr;
    end
endmodule // panel_clock_model

/* test_cpu_state_timers.sv */
`timescale 1ns/1ps
`include "cpu_state_consts.vh"
module test_cpu_state_timers;
    localparam int HALF = 250;
    localparam int INT_CYC = 10;
    logic clk, rst, ce, hsel, hwrite, readStopEn, writeStopEn, extClkSel, rtcDisable, runMode, instrDone;
    logic instrDouble, jumpTaken, memRefValid, memRefWrite, memRefOdd, regWe, tickRun, bpReq;
    logic class1Req, class2Req, class3Req;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] regSel;
    logic [5:0] memRefPage;
    logic [11:0] haddr;
    logic [15:0] jumpTarget, memRefAddr, regWData, bpValue;
    logic [31:0] hwdata, rd;
    wire hreadyout, hresp, extTick, panelBpLoad, stopped, intLockout, abortSeq;
    wire [31:0] hrdata;
    wire [15:0] pc, physAddr, regOut, panelBpAddr;
    wire [1:0] entryClass;
    int n_mismatch = 0;
    int num_checks = 0;
    // ========================================
    // Design and far side
    cpu_state_timers #(.TWO_SETS(1), .INT_TICK_CYC(INT_CYC)) cpu_state_timers_inst (.clk(clk), .rst(rst), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .panelBpLoad(panelBpLoad),
        .panelBpAddr(panelBpAddr), .readStopEn(readStopEn), .writeStopEn(writeStopEn), .extClkSel(extClkSel),
        .rtcDisable(rtcDisable), .extTick(extTick), .runMode(runMode), .instrDone(instrDone),
        .instrDouble(instrDouble), .jumpTaken(jumpTaken), .jumpTarget(jumpTarget), .memRefValid(memRefValid),
        .memRefWrite(memRefWrite), .memRefOdd(memRefOdd), .memRefPage(memRefPage), .memRefAddr(memRefAddr),
        .regSel(regSel), .regWe(regWe), .regWData(regWData), .class1Req(class1Req), .class2Req(class2Req),
        .class3Req(class3Req), .pc(pc), .physAddr(physAddr), .regOut(regOut), .stopped(stopped),
        .intLockout(intLockout), .abortSeq(abortSeq), .entryClass(entryClass));
    panel_clock_model #(.HALF(HALF)) panel_clock_model_inst (.clk(clk), .tickRun(tickRun), .bpReq(bpReq),
        .bpValue(bpValue), .extTick(extTick), .panelBpLoad(panelBpLoad), .panelBpAddr(panelBpAddr));
    // ========================================
    // Shared helpers
    task final_report;
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One single AHB-Lite transfer; read data lands in rd
    task bus(input logic w, input [11:0] a, input [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        hsize <= 3'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task rdchk(input [11:0] a, input [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp);
        chk(hresp, 1'b0);
    endtask
    task instr(input logic dbl, input logic jmp, input [15:0] tgt);
        instrDone <= 1'b1;
        instrDouble <= dbl;
        jumpTaken <= jmp;
        jumpTarget <= tgt;
        @(posedge clk);
        instrDone <= 1'b0;
        jumpTaken <= 1'b0;
        @(posedge clk);
    endtask
    task memref(input logic wr, input logic odd, input [5:0] pg, input [15:0] a);
        memRefValid <= 1'b1;
        memRefWrite <= wr;
        memRefOdd <= odd;
        memRefPage <= pg;
        memRefAddr <= a;
        @(posedge clk);
        memRefValid <= 1'b0;
        @(posedge clk);
    endtask
    // Exactly n external ticks at the top rate, then the line rests
    task ticks(input int n);
        tickRun <= 1'b1;
        cyc(n * 2 * HALF);
        tickRun <= 1'b0;
        cyc(20);
    endtask
    task wait_entry;
        int k;
        k = 0;
        while (intLockout !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        while (intLockout !== 1'b0 && k < 50) begin
            @(posedge clk);
            k++;
        end
        chk(k < 50, 1);
    endtask
    // ========================================
    // Scenarios
    task t_regs;
        bus(1'b1, `OFS_STATUS1, 32'h00000000);
        regSel <= 4'h3;
        regWData <= 16'h1111;
        regWe <= 1'b1;
        @(posedge clk);
        regWe <= 1'b0;
        bus(1'b1, `OFS_STATUS1, 32'h00004000);
        bus(1'b1, `OFS_GREG + 12'h00c, 32'h00002222);
        rdchk(`OFS_GREG + 12'h00c, 32'h00002222);
        chk(regOut, 32'h00002222);
        bus(1'b1, `OFS_STATUS1, 32'h00000000);
        rdchk(`OFS_GREG + 12'h00c, 32'h00001111);
        rdchk(12'h0fc, 32'h00000000);
    endtask
    task t_pc;
        runMode <= 1'b1;
        bus(1'b1, `OFS_PC, 32'h00000100);
        instr(1'b0, 1'b0, 16'h0000);
        chk(pc, 32'h00000101);
        instr(1'b1, 1'b0, 16'h0000);
        chk(pc, 32'h00000103);
        instr(1'b0, 1'b1, 16'h0200);
        chk(pc, 32'h00000200);
    endtask
    task t_page;
        bus(1'b1, `OFS_PAGE + 12'h014, 32'h00001000);
        memref(1'b0, 1'b0, 6'h05, 16'h0023);
        chk(physAddr, 32'h00001023);
    endtask
    task t_bp;
        bpValue <= 16'h0040;
        bpReq <= 1'b1;
        @(posedge clk);
        bpReq <= 1'b0;
        bus(1'b1, `OFS_BP, 32'h00001234);
        rdchk(`OFS_BP, 32'h00000040);
        readStopEn <= 1'b1;
        memref(1'b0, 1'b1, 6'h00, 16'h0040);
        instr(1'b0, 1'b0, 16'h0000);
        chk(stopped, 1'b0);
        memref(1'b0, 1'b0, 6'h00, 16'h0040);
        chk(stopped, 1'b0);
        instr(1'b0, 1'b0, 16'h0000);
        chk(stopped, 1'b1);
        bus(1'b1, `OFS_CMD, 32'h00000001);
        readStopEn <= 1'b0;
        writeStopEn <= 1'b1;
        memref(1'b0, 1'b0, 6'h00, 16'h0040);
        instr(1'b0, 1'b0, 16'h0000);
        chk(stopped, 1'b0);
        memref(1'b1, 1'b0, 6'h00, 16'h0040);
        instr(1'b0, 1'b0, 16'h0000);
        chk(stopped, 1'b1);
        bus(1'b1, `OFS_CMD, 32'h00000001);
        writeStopEn <= 1'b0;
    endtask
    task t_rtc;
        bus(1'b1, `OFS_RTC, 32'h0000fffe);
        bus(1'b1, `OFS_TCTRL, 32'h00000003);
        ticks(1);
        rdchk(`OFS_RTC, 32'h0000ffff);
        rtcDisable <= 1'b1;
        ticks(1);
        rtcDisable <= 1'b0;
        rdchk(`OFS_RTC, 32'h0000ffff);
        runMode <= 1'b0;
        ticks(1);
        runMode <= 1'b1;
        rdchk(`OFS_RTC, 32'h0000ffff);
        ticks(1);
        rdchk(`OFS_RTC, 32'h00010000);
        chk(entryClass, `CLS_TWO);
        chk(pc, `RST_ENTRY + 16'h0008);
        rdchk(`OFS_SAVRTC, 32'h00010000);
        bus(1'b1, `OFS_TCTRL, 32'h00000000);
    endtask
    task t_int;
        class1Req <= 1'b1;
        class2Req <= 1'b1;
        class3Req <= 1'b1;
        @(posedge clk);
        class1Req <= 1'b0;
        class2Req <= 1'b0;
        class3Req <= 1'b0;
        for (int k = 1; k <= 3; k++) begin
            wait_entry;
            chk(entryClass, k);
            chk(pc, `RST_ENTRY + 4 * k);
        end
        rdchk(`OFS_SAVPC, `RST_ENTRY + 32'h00000008);
    endtask
    task t_mon;
        bus(1'b1, `OFS_MON, 32'h00000002);
        bus(1'b1, `OFS_TCTRL, 32'h00000004);
        runMode <= 1'b0;
        ticks(1);
        runMode <= 1'b1;
        rdchk(`OFS_MON, 32'h00000002);
        ticks(1);
        rdchk(`OFS_MON, 32'h00000001);
        ticks(1);
        rdchk(`OFS_MON, 32'h00000000);
        rdchk(`OFS_TCTRL, 32'h00000000);
        chk(entryClass, `CLS_TWO);
    endtask
    task t_internal;
        extClkSel <= 1'b0;
        bus(1'b1, `OFS_RTC, 32'h00000000);
        bus(1'b1, `OFS_TCTRL, 32'h00000001);
        cyc(100);
        bus(1'b1, `OFS_TCTRL, 32'h00000000);
        extClkSel <= 1'b1;
        bus(1'b0, `OFS_RTC, 32'h00000000);
        chk(rd >= 100 / INT_CYC - 1 && rd <= 100 / INT_CYC + 1, 1);
    endtask
    // ========================================
    // Clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        cyc(20000);
        n_mismatch++;
        final_report;
    end
    initial begin
        {hsel, hwrite, readStopEn, writeStopEn, rtcDisable, runMode, instrDone, instrDouble, jumpTaken} = '0;
        {memRefValid, memRefWrite, memRefOdd, regWe, tickRun, bpReq, class1Req, class2Req, class3Req} = '0;
        {htrans, hsize, regSel, memRefPage, haddr, jumpTarget, memRefAddr, regWData, bpValue, hwdata} = '0;
        rst = 1'b1;
        ce = 1'b1;
        extClkSel = 1'b1;
        cyc(12);
        rst <= 1'b0;
        cyc(1);
        t_regs;
        t_pc;
        t_page;
        t_bp;
        t_rtc;
        t_int;
        t_mon;
        t_internal;
        final_report;
    end
endmodule // test_cpu_state_timers
